// ===== src/adaptive_dead_time_offsets.sv
// Adaptive dead time offsets for the first two PWM edges
`timescale 1ns/1ps

// Summary of operation
// [RULE1] Decode 3-bit threshold code to eight levels scaled by sense range
// [RULE2] Apply offsets only while sensed current is below threshold level
// [RULE3] Polarity bit zero shifts edge later, one shifts it earlier
// [RULE4] First edge magnitude in bits 6 to 4, 5 ns per step
// [RULE5] Second edge magnitude bits 2 to 0, sign from bit 3
// [RULE6] Change between offset and nominal timing only at period boundary
module adaptive_dead_time_offsets
  import dead_time_pkg::*;
(
  input  wire logic         sys_clk_in,
  input  wire logic         rst_b_in,
  input  wire logic [7:0]   reg_addr_in,
  input  wire logic [7:0]   reg_wdata_in,
  input  wire logic         reg_wr_in,
  input  wire logic         reg_rd_in,
  input  wire sense_range_t sense_range_in,
  input  wire logic [CUR_W-1:0] secondary_current_sense_in,
  input  wire edge_times_t  nominal_times_in,
  input  wire logic         period_start_in,
  output logic      [7:0]   reg_rdata_out,
  output edge_times_t       edge_times_out,
  output logic              light_load_out
);

  // ----------------------------------------------------------------
  // Register select
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SEL_NONE,
    SEL_THRESHOLD,
    SEL_FIRST_PAIR
  } reg_sel_t;

  function automatic reg_sel_t reg_select(
    input logic [7:0] addr
  );
    reg_sel_t sel;
    if (addr == ADDR_THRESHOLD) begin
      sel = SEL_THRESHOLD;
    end else if (addr == ADDR_FIRST_PAIR) begin
      sel = SEL_FIRST_PAIR;
    end else begin
      sel = SEL_NONE;
    end
    return sel;
  endfunction

  // ----------------------------------------------------------------
  // Internal state
  // ----------------------------------------------------------------
  logic [7:0]       dead_time_threshold;
  logic [7:0]       edge_offsets_first_pair;
  logic [7:0]       next_rdata;
  logic [CUR_W-1:0] level_uv;
  logic             below;
  logic             next_light_load;
  reg_sel_t         access_sel;
  edge_offset_t     first_offset;
  edge_offset_t     second_offset;
  edge_times_t      offset_times;
  edge_times_t      next_times;

  assign access_sel = reg_select(reg_addr_in);

  // ----------------------------------------------------------------
  // Threshold register
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      dead_time_threshold <= RESET_THRESHOLD;
    end else if (reg_wr_in && access_sel == SEL_THRESHOLD) begin
      dead_time_threshold <= reg_wdata_in;
    end
  end

  // ----------------------------------------------------------------
  // Edge offset register
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      edge_offsets_first_pair <= RESET_FIRST_PAIR;
    end else if (reg_wr_in && access_sel == SEL_FIRST_PAIR) begin
      edge_offsets_first_pair <= reg_wdata_in;
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  always_comb begin
    next_rdata = 8'h00;
    if (access_sel == SEL_THRESHOLD) begin
      next_rdata = dead_time_threshold;
    end else if (access_sel == SEL_FIRST_PAIR) begin
      next_rdata = edge_offsets_first_pair;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      reg_rdata_out <= 8'h00;
    end else if (reg_rd_in) begin
      reg_rdata_out <= next_rdata;
    end
  end

  // ----------------------------------------------------------------
  // Offset fields
  // ----------------------------------------------------------------
  // [RULE4] Bits 7 to 4
  assign first_offset =
    edge_offsets_first_pair[FIRST_POL_BIT:FIRST_MAG_LSB];

  // [RULE5] Bits 3 to 0
  assign second_offset =
    edge_offsets_first_pair[SECOND_POL_BIT:SECOND_MAG_LSB];

  // ----------------------------------------------------------------
  // Threshold level
  // ----------------------------------------------------------------
  threshold_decoder u_decoder (
    .code_in      (dead_time_threshold[THR_CODE_LSB +: THR_CODE_W]),
    .range_in     (sense_range_in),
    .level_uv_out (level_uv)
  );

  // ----------------------------------------------------------------
  // Light load compare
  // ----------------------------------------------------------------
  function automatic logic below_level(
    input logic [CUR_W-1:0] current,
    input logic [CUR_W-1:0] level
  );
    return current < level;
  endfunction

  // [RULE2] Strictly below level
  assign below = below_level(secondary_current_sense_in, level_uv);

  // ----------------------------------------------------------------
  // Edge offset arithmetic
  // ----------------------------------------------------------------
  function automatic logic [TIME_W-1:0] offset_delta(
    input logic [MAG_W-1:0] magnitude
  );
    return TIME_W'(magnitude) * TIME_W'(STEP_CYCLES);
  endfunction

  function automatic logic [TIME_W-1:0] apply_offset(
    input logic [TIME_W-1:0] nominal,
    input edge_offset_t      off
  );
    logic [TIME_W-1:0] delta;
    delta = offset_delta(off.magnitude);
    // [RULE3] Sign from polarity
    if (off.polarity) begin
      apply_offset = (nominal > delta) ? nominal - delta : '0;
    end else begin
      apply_offset = nominal + delta;
    end
  endfunction

  always_comb begin
    offset_times = nominal_times_in;
    // [RULE4] First edge shift
    offset_times.first_edge_timing = apply_offset(
      nominal_times_in.first_edge_timing, first_offset);
    // [RULE5] Second edge shift
    offset_times.second_edge_timing = apply_offset(
      nominal_times_in.second_edge_timing, second_offset);
  end

  // ----------------------------------------------------------------
  // Period boundary mode
  // ----------------------------------------------------------------
  // [RULE6] Mode moves at boundary
  always_comb begin
    next_light_load = light_load_out;
    if (period_start_in) begin
      next_light_load = below;
    end
  end

  // ----------------------------------------------------------------
  // Edge selection
  // ----------------------------------------------------------------
  // [RULE2] Offsets in light load
  always_comb begin
    next_times = nominal_times_in;
    if (next_light_load) begin
      next_times = offset_times;
    end
  end

  // ----------------------------------------------------------------
  // Light load flag
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      light_load_out <= 1'b0;
    end else begin
      light_load_out <= next_light_load;
    end
  end

  // ----------------------------------------------------------------
  // Edge times
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      edge_times_out <= '0;
    end else begin
      edge_times_out <= next_times;
    end
  end

endmodule

// ===== src/dead_time_pkg.sv
// Constants and types for the adaptive dead time offset block
package dead_time_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_THRESHOLD   = 8'h68;
  localparam logic [7:0] ADDR_FIRST_PAIR  = 8'h69;
  localparam logic [7:0] RESET_THRESHOLD  = 8'h00;
  localparam logic [7:0] RESET_FIRST_PAIR = 8'h00;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int THR_CODE_LSB   = 0;
  localparam int THR_CODE_W     = 3;
  localparam int FIRST_POL_BIT  = 7;
  localparam int FIRST_MAG_LSB  = 4;
  localparam int SECOND_POL_BIT = 3;
  localparam int SECOND_MAG_LSB = 0;
  localparam int MAG_W          = 3;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS   = 5000;
  localparam int OFFSET_STEP_PS  = 5000;
  localparam int STEP_CYCLES     = OFFSET_STEP_PS / CLK_PERIOD_PS;
  localparam int TIME_W          = 16;

  // ----------------------------------------------------------------
  // Current sense ranges, level width in microvolts and edge types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    RANGE_37MV5,
    RANGE_75MV,
    RANGE_150MV
  } sense_range_t;

  localparam int CUR_W = 20;

  typedef struct packed {
    logic [TIME_W-1:0] first_edge_timing;
    logic [TIME_W-1:0] second_edge_timing;
  } edge_times_t;

  typedef struct packed {
    logic             polarity;
    logic [MAG_W-1:0] magnitude;
  } edge_offset_t;

endpackage

// ===== src/threshold_decoder.sv
// Decoder from threshold code and sense range to a current level
`timescale 1ns/1ps

module threshold_decoder
  import dead_time_pkg::*;
(
  input  wire logic [THR_CODE_W-1:0] code_in,
  input  wire sense_range_t          range_in,
  output logic      [CUR_W-1:0]      level_uv_out
);

  // ----------------------------------------------------------------
  // Level table
  // ----------------------------------------------------------------
  always_comb begin
    level_uv_out = 20'h00000;
    // [RULE1] Eight step table
    case (range_in)
      RANGE_37MV5: begin
        case (code_in)
          3'h1: level_uv_out = 20'h00F3C;
          3'h2: level_uv_out = 20'h01E78;
          3'h3: level_uv_out = 20'h02DB4;
          3'h4: level_uv_out = 20'h03C8C;
          3'h5: level_uv_out = 20'h04C2C;
          3'h6: level_uv_out = 20'h05BCC;
          3'h7: level_uv_out = 20'h06978;
          default: level_uv_out = 20'h00000;
        endcase
      end
      RANGE_75MV: begin
        case (code_in)
          3'h1: level_uv_out = 20'h01E78;
          3'h2: level_uv_out = 20'h03CF0;
          3'h3: level_uv_out = 20'h05BCC;
          3'h4: level_uv_out = 20'h07918;
          3'h5: level_uv_out = 20'h09858;
          3'h6: level_uv_out = 20'h0B798;
          3'h7: level_uv_out = 20'h0D2F0;
          default: level_uv_out = 20'h00000;
        endcase
      end
      RANGE_150MV: begin
        case (code_in)
          3'h1: level_uv_out = 20'h03CF0;
          3'h2: level_uv_out = 20'h07A12;
          3'h3: level_uv_out = 20'h0B798;
          3'h4: level_uv_out = 20'h0F424;
          3'h5: level_uv_out = 20'h130B0;
          3'h6: level_uv_out = 20'h16F30;
          3'h7: level_uv_out = 20'h1A9C8;
          default: level_uv_out = 20'h00000;
        endcase
      end
      default: level_uv_out = 20'h00000;
    endcase
  end

endmodule

// ===== test/adaptive_dead_time_offsets_bench.sv
// Bench for the adaptive dead time offsets
`timescale 1ns/1ps
module adaptive_dead_time_offsets_bench
  import dead_time_pkg::*;
;
  logic         clk, rst_b, wr, rd, ps, ll;
  logic [7:0]   addr, wdata, rdata;
  logic [19:0]  cur;
  sense_range_t rng;
  edge_times_t  nom, eto, app;
  int           num_errors = 0;
  int           n_tests = 0;
  int lvl [3][7] = '{'{3900, 7800, 11700, 15500, 19500, 23500, 27000},
    '{7800, 15600, 23500, 31000, 39000, 47000, 54000},
    '{15600, 31250, 47000, 62500, 78000, 94000, 109000}};
  adaptive_dead_time_offsets u_dut (.sys_clk_in(clk), .rst_b_in(rst_b),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr),
    .reg_rd_in(rd), .sense_range_in(rng), .secondary_current_sense_in(cur),
    .nominal_times_in(nom), .period_start_in(ps), .reg_rdata_out(rdata),
    .edge_times_out(eto), .light_load_out(ll));
  switch_driver_model u_stage (.sys_clk_in(clk), .times_in(eto),
    .applied_out(app));
  initial begin
    clk = 0;
    forever #2.5 clk = ~clk;
  end
  task automatic chk(logic [32:0] seen, logic [32:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %0t seen %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wr_reg(logic [7:0] a, logic [7:0] d);
    @(negedge clk);
    {addr, wdata, wr} = {a, d, 1'b1};
    @(negedge clk) wr = 0;
  endtask
  task automatic rd_reg(logic [7:0] a, logic [7:0] e);
    @(negedge clk);
    {addr, rd} = {a, 1'b1};
    @(negedge clk) rd = 0;
    chk({25'h0, rdata}, {25'h0, e});
  endtask
  task automatic period(int c, logic l, int f, int s);
    @(negedge clk);
    {cur, ps} = {c[19:0], 1'b1};
    @(negedge clk) ps = 0;
    chk({ll, eto}, {l, f[15:0], s[15:0]});
  endtask
  task automatic stop_test;
    $display("errors %0d checks %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    {rst_b, wr, rd, ps, addr, wdata, cur} = '0;
    rng = RANGE_37MV5;
    nom = {16'h0064, 16'h0064};
    repeat (9) @(negedge clk);
    rst_b = 1;
    rd_reg(ADDR_THRESHOLD, RESET_THRESHOLD);
    rd_reg(ADDR_FIRST_PAIR, RESET_FIRST_PAIR);
    wr_reg(8'h6A, 8'hFF);
    rd_reg(8'h6A, 8'h00);
    wr_reg(ADDR_THRESHOLD, 8'hF8);
    rd_reg(ADDR_THRESHOLD, 8'hF8);
    wr_reg(ADDR_FIRST_PAIR, 8'h11);
    period(0, 0, 100, 100);
    for (int r = 0; r < 3; r++) begin
      rng = sense_range_t'(r);
      for (int c = 1; c < 8; c++) begin
        wr_reg(ADDR_THRESHOLD, 8'(c));
        period(lvl[r][c-1] - 1, 1, 101, 101);
        period(lvl[r][c-1], 0, 100, 100);
      end
    end
    wr_reg(ADDR_THRESHOLD, 8'h07);
    for (int m = 0; m < 8; m++) begin
      wr_reg(ADDR_FIRST_PAIR, {1'b0, 3'(m), 1'b1, 3'(7 - m)});
      period(0, 1, 100 + m, 100 - (7 - m));
      wr_reg(ADDR_FIRST_PAIR, {1'b1, 3'(m), 1'b0, 3'(7 - m)});
      period(0, 1, 100 - m, 100 + (7 - m));
    end
    nom = {16'h0064, 16'h0003};
    wr_reg(ADDR_FIRST_PAIR, 8'h0F);
    period(0, 1, 100, 0);
    @(negedge clk) cur = 20'd200000;
    repeat (3) @(negedge clk);
    chk({ll, eto}, {1'b1, 16'd100, 16'd0});
    period(200000, 0, 100, 3);
    rng = sense_range_t'(2'h3);
    period(0, 0, 100, 3);
    @(negedge clk);
    chk({1'b0, app}, {1'b0, 16'd100, 16'd3});
    stop_test;
  end
  initial begin
    #20000;
    num_errors++;
    stop_test;
  end
endmodule

// ===== test/dead_time_chk.sv
// Checker for the adaptive dead time offsets
`timescale 1ns/1ps
module dead_time_chk
  import dead_time_pkg::*;
(
  input wire logic             sys_clk_in,
  input wire logic             rst_b_in,
  input wire logic [7:0]       reg_addr_in,
  input wire logic [7:0]       reg_wdata_in,
  input wire logic             reg_wr_in,
  input wire logic [CUR_W-1:0] secondary_current_sense_in,
  input wire edge_times_t      nominal_times_in,
  input wire logic             period_start_in,
  input wire edge_times_t      edge_times_out,
  input wire logic             light_load_out
);
  logic [7:0] pair;
  always_ff @(posedge sys_clk_in)
    if (!rst_b_in) pair <= 8'h00;
    else if (reg_wr_in && reg_addr_in == ADDR_FIRST_PAIR)
      pair <= reg_wdata_in;
  function automatic logic [15:0] adj(logic [15:0] n, logic [3:0] f);
    logic [15:0] m;
    m = 16'(f[2:0]) * 16'(STEP_CYCLES);
    adj = f[3] ? ((n > m) ? n - m : 16'h0000) : n + m;
  endfunction
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rst_b_in);
  a_mode_holds: assert property (
    !period_start_in |=> $stable(light_load_out)) else $error("mode moved");
  a_rise_boundary: assert property (
    $rose(light_load_out) |-> $past(period_start_in)) else $error("rise");
  a_top_step: assert property (
    period_start_in && secondary_current_sense_in >= 20'd109000
    |=> !light_load_out) else $error("above top step");
  a_nominal_pass: assert property (
    !light_load_out && $past(rst_b_in)
    |-> edge_times_out == $past(nominal_times_in)) else $error("nominal");
  a_first_offset: assert property (
    light_load_out && $past(rst_b_in) |-> edge_times_out.first_edge_timing
    == adj($past(nominal_times_in.first_edge_timing), $past(pair[7:4])))
    else $error("first edge");
  a_second_offset: assert property (
    light_load_out && $past(rst_b_in) |-> edge_times_out.second_edge_timing
    == adj($past(nominal_times_in.second_edge_timing), $past(pair[3:0])))
    else $error("second edge");
endmodule
bind adaptive_dead_time_offsets dead_time_chk u_chk (.sys_clk_in,
  .rst_b_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in,
  .secondary_current_sense_in, .nominal_times_in, .period_start_in,
  .edge_times_out, .light_load_out);

// ===== test/switch_driver_model.sv
// Power stage switch driver model
`timescale 1ns/1ps
module switch_driver_model
  import dead_time_pkg::*;
(
  input  wire logic        sys_clk_in,
  input  wire edge_times_t times_in,
  output edge_times_t      applied_out
);
  always_ff @(posedge sys_clk_in) applied_out <= times_in;
endmodule
